// file: bcis_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module bcis_host_model #(
  parameter int unsigned BIT_CYC = bcis_pkg::BIT_CYC
) (
  input wire logic clk,
  input wire logic reply_line,
  output logic cmd_rx
);
  logic [7:0] rx_q[$];
  logic [7:0] sh;
  initial cmd_rx = 1'b1;
  // Sends one character, start bit, LSB first, stop bit
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      cmd_rx <= fr[i];
      repeat (BIT_CYC - 1) @(posedge clk);
    end
  endtask
  // Whole command, as the controller issues it
  task automatic send_cmd(input string s);
    for (int i = 0; i < s.len(); i++) begin
      send_byte(s[i]);
    end
  endtask
  // Reply receiver, mid-bit sampling, bad stop drops the character
  always begin
    @(negedge reply_line);
    repeat (BIT_CYC / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge clk);
      sh[i] = reply_line;
    end
    repeat (BIT_CYC) @(posedge clk);
    if (reply_line === 1'b1) begin
      rx_q.push_back(sh);
    end
  end
endmodule
`default_nettype wire

// file: bcis_pkg.sv
package bcis_pkg;
  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned BAUD = 19200;
  localparam int unsigned BIT_CYC = CLK_HZ / BAUD;
  localparam int unsigned HALF_CYC = BIT_CYC / 2;
  localparam logic [7:0] CH_FRAME = 8'h58;
  localparam logic [7:0] CH_COLON = 8'h3A;
  localparam logic [7:0] CH_VER = 8'h56;
  localparam logic [7:0] CH_C = 8'h43;
  localparam logic [7:0] CH_Z = 8'h5A;
  localparam logic [7:0] CH_P = 8'h50;
  localparam logic [7:0] CH_S = 8'h53;
  localparam logic [7:0] CH_UND = 8'h5F;
  localparam logic [7:0] CH_D = 8'h44;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [3:0] ADDR_BCAST = 4'h9;
  localparam logic [1:0] SEL_RST = 2'h0;
  localparam logic [1:0] SEL_I2C = 2'h0;
  localparam logic [1:0] SEL_ONE_WIRE = 2'h1;
  localparam int unsigned VER_LEN = 4;
  localparam logic [31:0] VER_STR = 32'h56322E31;
endpackage

// file: bcis_top.sv
`timescale 1ns/1ns
`default_nettype none
module bcis_top #(
  parameter int unsigned BIT_CYC = bcis_pkg::BIT_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmd_rx,
  input wire logic [2:0] address_jumpers,
  input wire logic [23:0] dut_power_req,
  input wire logic [2:0] pullup_req,
  output logic reply_tx_o,
  output logic reply_tx_oe,
  output logic iface_select_low,
  output logic iface_select_high,
  output logic addr_indicator_a,
  output logic addr_indicator_b,
  output logic addr_indicator_c,
  output logic [23:0] dut_power_en,
  output logic [2:0] pullup_en
);
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} bcis_rx_t;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} bcis_tx_t;
  localparam int unsigned HALF_CYC = BIT_CYC / 2;

  logic rx_s1_q, rx_s2_q;
  logic [2:0] jmp_s1_q, jmp_s2_q;
  logic [2:0] addr_q, addr_d;
  bcis_rx_t rxs_q, rxs_d;
  logic [15:0] rcnt_q, rcnt_d;
  logic [2:0] rbit_q, rbit_d;
  logic [7:0] rsh_q, rsh_d;
  logic rdone;
  logic [7:0] b0_q, b1_q, b2_q, b3_q, b4_q, b5_q, b6_q, b7_q, b8_q;
  logic [7:0] b0_d, b1_d, b2_d, b3_d, b4_d, b5_d, b6_d, b7_d, b8_d;
  logic [1:0] sel_q, sel_d;
  logic ver_go;
  bcis_tx_t txs_q, txs_d;
  logic [15:0] tcnt_q, tcnt_d;
  logic [2:0] tbit_q, tbit_d;
  logic [2:0] tidx_q, tidx_d;
  logic [7:0] tsh_q, tsh_d;
  logic tx_q, tx_d, toe_q, toe_d;
  logic hit;
  logic [1:0] rel_q, rel_d;

  // Two-stage synchronisers for pins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      jmp_s1_q <= 3'h0;
      jmp_s2_q <= 3'h0;
    end else begin
      rx_s1_q <= cmd_rx;
      rx_s2_q <= rx_s1_q;
      jmp_s1_q <= address_jumpers;
      jmp_s2_q <= jmp_s1_q;
    end
  end

  always_comb begin
    addr_d = ~jmp_s2_q;
    rel_d = (rel_q == 2'h3) ? rel_q : rel_q + 2'h1;
  end

  // Serial receiver
  always_comb begin
    rxs_d = rxs_q;
    rcnt_d = rcnt_q;
    rbit_d = rbit_q;
    rsh_d = rsh_q;
    rdone = 1'b0;
    case (rxs_q)
      RX_IDLE: begin
        rcnt_d = 16'h0;
        if (!rx_s2_q) begin
          rxs_d = RX_START;
        end
      end
      RX_START: begin
        rcnt_d = rcnt_q + 16'h1;
        if (rcnt_q == 16'(HALF_CYC)) begin
          rcnt_d = 16'h0;
          rbit_d = 3'h0;
          rxs_d = rx_s2_q ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        rcnt_d = rcnt_q + 16'h1;
        if (rcnt_q == 16'(BIT_CYC - 1)) begin
          rcnt_d = 16'h0;
          rsh_d = {rx_s2_q, rsh_q[7:1]};
          rbit_d = rbit_q + 3'h1;
          if (rbit_q == 3'h7) begin
            rxs_d = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        rcnt_d = rcnt_q + 16'h1;
        if (rcnt_q == 16'(BIT_CYC - 1)) begin
          rxs_d = RX_IDLE;
          rdone = rx_s2_q;
        end
      end
      default: rxs_d = RX_IDLE;
    endcase
  end

  // Command decode over the last received characters
  always_comb begin
    {b8_d, b7_d, b6_d, b5_d, b4_d, b3_d, b2_d, b1_d, b0_d} =
      {b8_q, b7_q, b6_q, b5_q, b4_q, b3_q, b2_q, b1_q, b0_q};
    sel_d = sel_q;
    ver_go = 1'b0;
    hit = 1'b0;
    if (rdone) begin
      {b8_d, b7_d, b6_d, b5_d, b4_d, b3_d, b2_d, b1_d, b0_d} =
        {b7_q, b6_q, b5_q, b4_q, b3_q, b2_q, b1_q, b0_q, rsh_q};
      if (rsh_q == bcis_pkg::CH_FRAME && b0_q == bcis_pkg::CH_COLON) begin
        if (b3_q == bcis_pkg::CH_FRAME && b1_q == bcis_pkg::CH_VER &&
            b2_q == {4'h3, 1'b0, addr_q}) begin
          ver_go = 1'b1;
        end
        hit = b4_q == {4'h3, bcis_pkg::ADDR_BCAST} || b4_q == {4'h3, 1'b0, addr_q};
        if (b5_q == bcis_pkg::CH_FRAME && hit && b3_q == bcis_pkg::CH_C &&
            b2_q == bcis_pkg::CH_Z && b1_q[7:1] == 7'h18) begin
          sel_d = b1_q[0] ? bcis_pkg::SEL_ONE_WIRE : bcis_pkg::SEL_I2C;
        end
        if (b8_q == bcis_pkg::CH_FRAME && b7_q[7:4] == 4'h3 && b1_q[7:1] == 7'h18 &&
            (b7_q[3:0] == bcis_pkg::ADDR_BCAST || b7_q[3:0] == {1'b0, addr_q}) &&
            b6_q == bcis_pkg::CH_P && b5_q == bcis_pkg::CH_S &&
            b4_q == bcis_pkg::CH_UND && b3_q == bcis_pkg::CH_D) begin
          if (b2_q == 8'h32) begin
            sel_d[0] = b1_q[0];
          end
          if (b2_q == 8'h33) begin
            sel_d[1] = b1_q[0];
          end
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxs_q <= RX_IDLE;
      rcnt_q <= 16'h0;
      rbit_q <= 3'h0;
      rsh_q <= 8'h0;
      {b8_q, b7_q, b6_q, b5_q, b4_q, b3_q, b2_q, b1_q, b0_q} <= 72'h0;
      sel_q <= bcis_pkg::SEL_RST;
      addr_q <= 3'h0;
      rel_q <= 2'h0;
    end else begin
      rxs_q <= rxs_d;
      rcnt_q <= rcnt_d;
      rbit_q <= rbit_d;
      rsh_q <= rsh_d;
      {b8_q, b7_q, b6_q, b5_q, b4_q, b3_q, b2_q, b1_q, b0_q} <=
        {b8_d, b7_d, b6_d, b5_d, b4_d, b3_d, b2_d, b1_d, b0_d};
      sel_q <= sel_d;
      addr_q <= addr_d;
      rel_q <= rel_d;
    end
  end

  // Reply transmitter for the version string
  always_comb begin
    txs_d = txs_q;
    tcnt_d = tcnt_q + 16'h1;
    tbit_d = tbit_q;
    tidx_d = tidx_q;
    tsh_d = tsh_q;
    tx_d = tx_q;
    toe_d = toe_q;
    case (txs_q)
      TX_IDLE: begin
        tx_d = 1'b1;
        toe_d = 1'b0;
        tcnt_d = 16'h0;
        if (ver_go) begin
          tidx_d = 3'h0;
          tsh_d = bcis_pkg::VER_STR[31:24];
          toe_d = 1'b1;
          tx_d = 1'b0;
          txs_d = TX_START;
        end
      end
      TX_START: begin
        if (tcnt_q == 16'(BIT_CYC - 1)) begin
          tcnt_d = 16'h0;
          tbit_d = 3'h0;
          tx_d = tsh_q[0];
          txs_d = TX_DATA;
        end
      end
      TX_DATA: begin
        if (tcnt_q == 16'(BIT_CYC - 1)) begin
          tcnt_d = 16'h0;
          tbit_d = tbit_q + 3'h1;
          tsh_d = {1'b0, tsh_q[7:1]};
          tx_d = tsh_q[1];
          if (tbit_q == 3'h7) begin
            tx_d = 1'b1;
            txs_d = TX_STOP;
          end
        end
      end
      TX_STOP: begin
        if (tcnt_q == 16'(BIT_CYC - 1)) begin
          tcnt_d = 16'h0;
          tidx_d = tidx_q + 3'h1;
          if (tidx_q == 3'(bcis_pkg::VER_LEN - 1)) begin
            txs_d = TX_IDLE;
            toe_d = 1'b0;
          end else begin
            tsh_d = bcis_pkg::VER_STR[8 * (2 - tidx_q) +: 8];
            tx_d = 1'b0;
            txs_d = TX_START;
          end
        end
      end
      default: txs_d = TX_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txs_q <= TX_IDLE;
      tcnt_q <= 16'h0;
      tbit_q <= 3'h0;
      tidx_q <= 3'h0;
      tsh_q <= 8'h0;
      tx_q <= 1'b1;
      toe_q <= 1'b0;
    end else begin
      txs_q <= txs_d;
      tcnt_q <= tcnt_d;
      tbit_q <= tbit_d;
      tidx_q <= tidx_d;
      tsh_q <= tsh_d;
      tx_q <= tx_d;
      toe_q <= toe_d;
    end
  end

  assign reply_tx_o = tx_q;
  assign reply_tx_oe = toe_q;
  assign iface_select_low = sel_q[0];
  assign iface_select_high = sel_q[1];
  assign {addr_indicator_c, addr_indicator_b, addr_indicator_a} = addr_q;
  assign dut_power_en = dut_power_req;
  assign pullup_en = pullup_req;

  chk_idle_released: assert property (@(posedge clk) disable iff (!rst_n)
    txs_q == TX_IDLE |-> !reply_tx_oe) else $error("reply driven while idle");
  chk_ver_starts: assert property (@(posedge clk) disable iff (!rst_n)
    ver_go && txs_q == TX_IDLE |=> reply_tx_oe && !reply_tx_o) else $error("no start bit");
  chk_addr_show: assert property (@(posedge clk) disable iff (!rst_n)
    rel_q == 2'h3 |-> addr_q == ~$past(address_jumpers, 3))
    else $error("address wrong");
  chk_sel_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !rdone |=> $stable(sel_q)) else $error("select moved without command");
  chk_led_match: assert property (@(posedge clk) disable iff (!rst_n)
    rel_q == 2'h3 |->
    {addr_indicator_c, addr_indicator_b, addr_indicator_a} == ~$past(address_jumpers, 3))
    else $error("led");
  chk_pwr_pass: assert property (@(posedge clk) disable iff (!rst_n)
    dut_power_en == dut_power_req) else $error("power mux");
  chk_pull_pass: assert property (@(posedge clk) disable iff (!rst_n)
    pullup_en == pullup_req) else $error("pull-up");
  chk_enable_one_wire: assert property (@(posedge clk) disable iff (!rst_n)
    rdone && rsh_q == bcis_pkg::CH_FRAME && b0_q == bcis_pkg::CH_COLON &&
    b1_q == 8'h31 && b2_q == bcis_pkg::CH_Z && b3_q == bcis_pkg::CH_C &&
    b4_q == 8'h39 && b5_q == bcis_pkg::CH_FRAME |=> sel_q == bcis_pkg::SEL_ONE_WIRE)
    else $error("enable failed");
endmodule
`default_nettype wire

// file: test_bcis_top.sv
`timescale 1ns/1ns
`default_nettype none
module test_bcis_top;
  logic clk = 1'b0;
  logic rst_n;
  logic cmd_rx;
  logic [2:0] jmp;
  logic [23:0] pwr_req;
  logic [2:0] pu_req;
  logic tx, oe, sel_lo, sel_hi, ind_a, ind_b, ind_c;
  logic [23:0] pwr_en;
  logic [2:0] pu_en;
  wire reply_line;
  int error_cnt = 0;
  int n_compared = 0;
  int hits;
  string cmds[6];
  logic [1:0] sel_exp[6];
  // Short bit period keeps the run brief; the design defaults to the real rate
  localparam int unsigned FAST_CYC = 40;
  always #50 clk = ~clk;
  // Released line is held high by the pull-up
  assign reply_line = oe ? tx : 1'b1;
  bcis_top #(.BIT_CYC(FAST_CYC)) bcis_top_inst (.clk(clk), .rst_n(rst_n), .cmd_rx(cmd_rx),
    .address_jumpers(jmp),
    .dut_power_req(pwr_req), .pullup_req(pu_req), .reply_tx_o(tx), .reply_tx_oe(oe),
    .iface_select_low(sel_lo), .iface_select_high(sel_hi), .addr_indicator_a(ind_a),
    .addr_indicator_b(ind_b), .addr_indicator_c(ind_c), .dut_power_en(pwr_en),
    .pullup_en(pu_en));
  bcis_host_model #(.BIT_CYC(FAST_CYC)) bcis_host_model_inst (.clk(clk),
    .reply_line(reply_line), .cmd_rx(cmd_rx));
  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Whole test needs about 33000 cycles at the short bit period
  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    end_sim();
  end
  initial begin
    rst_n = 1'b0;
    jmp = 3'h6;
    pwr_req = 24'h000000;
    pu_req = 3'h0;
    cmds = '{"X9CZ1:X", "X9PS_D31:X", "X9PS_D20:X", "X9CZ0:X", "X1PS_D21:X", "X2PS_D31:X"};
    sel_exp = '{2'h1, 2'h3, 2'h2, 2'h0, 2'h1, 2'h1};
    repeat (2) @(posedge clk);
    #10;
    chk({tx, oe, sel_hi, sel_lo, ind_c, ind_b, ind_a}, 24'h40, "reset values");
    chk(24'(bcis_pkg::BIT_CYC), 24'(10000000 / 19200), "bit period at 19200 baud");
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    #10;
    chk({ind_c, ind_b, ind_a}, 24'h1, "address 1 indicators");
    for (int i = 0; i < 6; i++) begin
      bcis_host_model_inst.send_cmd(cmds[i]);
      repeat (3) @(posedge clk);
      #10;
      chk({sel_hi, sel_lo}, sel_exp[i], cmds[i]);
      chk(oe, 1'b0, "reply line after select");
    end
    bcis_host_model_inst.send_cmd("X1V:X");
    for (int k = 0; k < 8000 && bcis_host_model_inst.rx_q.size() < 4; k++) @(posedge clk);
    chk(bcis_host_model_inst.rx_q.size(), 4, "version length");
    for (int i = 0; i < 4 && bcis_host_model_inst.rx_q.size() > 0; i++) begin
      chk(bcis_host_model_inst.rx_q.pop_front(), bcis_pkg::VER_STR[31-8*i -: 8], "ver");
    end
    bcis_host_model_inst.send_cmd("X2V:X");
    hits = 0;
    repeat (6000) begin
      @(posedge clk);
      #10;
      hits += (oe !== 1'b0);
    end
    chk(hits, 0, "foreign version read drove line");
    chk(bcis_host_model_inst.rx_q.size(), 0, "foreign version reply");
    @(posedge clk);
    jmp <= 3'h7;
    repeat (4) @(posedge clk);
    #10;
    chk({ind_c, ind_b, ind_a}, 24'h0, "address 0 indicators");
    @(posedge clk);
    jmp <= 3'h0;
    pwr_req <= 24'hA55AC3;
    pu_req <= 3'h5;
    repeat (4) @(posedge clk);
    #10;
    chk({ind_c, ind_b, ind_a}, 24'h7, "address 7 indicators");
    chk(pwr_en, 24'hA55AC3, "power mux");
    chk(pu_en, 24'h5, "pull-up switches");
    end_sim();
  end
endmodule
`default_nettype wire
